// [verilog/tbac_mac.sv]
// Token bus medium access controller with host register port
`timescale 1ns/10ps
module tbac_mac
   import tbac_pkg::*;
#(
   parameter int SILENCE_CYC = 12500,
   parameter int CYCLE_UNIT_CYC = 125000
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] addrTensSw,
   input wire logic [3:0] addrOnesSw,
   input wire logic [3:0] unitSw,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire logic rxValid,
   input wire logic [2:0] rxKind,
   input wire logic [5:0] rxDest,
   input wire logic [5:0] rxSrc,
   input wire logic [15:0] rxPayload,
   output logic txValid,
   output logic [2:0] txKind,
   output logic [5:0] txDest,
   output logic [5:0] txSrc,
   output logic [15:0] txPayload,
   output logic addrErr,
   output logic pollerActive,
   output logic tokenHeld
);

   // ---------------------------------------------------------------
   // Switch synchronisers
   // ---------------------------------------------------------------
   logic [3:0] tensS1, tensS2, onesS1, onesS2, unitS1, unitS2;

   always_ff @(posedge clock) begin
      tensS1 <= addrTensSw;
      tensS2 <= tensS1;
      onesS1 <= addrOnesSw;
      onesS2 <= onesS1;
      unitS1 <= unitSw;
      unitS2 <= unitS1;
   end

   // Lowest member strictly above an address; bit 6 marks found
   function automatic logic [6:0] first_above(input logic [63:0] map, input logic [5:0] a);
      logic [6:0] r;
      r = 7'h00;
      for (int i = 63; i >= 0; i--) begin
         if (map[i] && (6'(i) > a)) begin
            r = {1'b1, 6'(i)};
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   tbac_state_t state, next_state;
   logic isPoller, next_isPoller;
   logic [63:0] memberMap, next_memberMap;
   logic [31:0] rxParam, next_rxParam;
   logic linkRun, next_linkRun;
   logic autoAlloc, next_autoAlloc;
   logic [31:0] paramMem, next_paramMem;
   logic [31:0] paramCommon, next_paramCommon;
   logic [15:0] txData, next_txData;
   logic txPending, next_txPending;
   logic [15:0] rxData, next_rxData;
   logic [5:0] rxFrom, next_rxFrom;
   logic rxNew, next_rxNew;
   logic [5:0] pollAddr, next_pollAddr;
   logic [7:0] pollLeft, next_pollLeft;
   logic [15:0] waitCnt, next_waitCnt;
   logic [2:0] bcastIdx, next_bcastIdx;
   logic [31:0] silenceCnt, next_silenceCnt;
   logic [31:0] cyclePre, next_cyclePre;
   logic [7:0] cycleMs, next_cycleMs;
   logic next_txValid;
   logic [2:0] next_txKind;
   logic [5:0] next_txDest;
   logic [15:0] next_txPayload;
   logic [31:0] next_regRdData;

   logic [7:0] addrBin;
   logic addrValid;
   logic [5:0] ownAddr;
   logic [31:0] localParam, effParam;
   logic [5:0] maxNode;
   logic [6:0] nextUp, lowest;

   always_comb begin
      addrBin = 8'({4'h0, tensS2} * 8'd10) + {4'h0, onesS2};
      addrValid = (tensS2 <= 4'h9) && (onesS2 <= 4'h9) &&
                  (addrBin >= ADDR_LOWEST) && (addrBin <= ADDR_HIGHEST);
      ownAddr = addrBin[5:0];
      localParam = autoAlloc ? paramMem : paramCommon;
      effParam = isPoller ? localParam : rxParam;
      maxNode = effParam[PAR_MAXNODE +: 6];
      nextUp = first_above(memberMap, ownAddr);
      lowest = first_above(memberMap, 6'h00);
   end

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_isPoller = isPoller;
      next_memberMap = memberMap;
      next_rxParam = rxParam;
      next_linkRun = linkRun;
      next_autoAlloc = autoAlloc;
      next_paramMem = paramMem;
      next_paramCommon = paramCommon;
      next_txData = txData;
      next_txPending = txPending;
      next_rxData = rxData;
      next_rxFrom = rxFrom;
      next_rxNew = rxNew;
      next_pollAddr = pollAddr;
      next_pollLeft = pollLeft;
      next_waitCnt = waitCnt;
      next_bcastIdx = bcastIdx;
      next_silenceCnt = silenceCnt + 32'h0000_0001;
      next_cyclePre = cyclePre;
      next_cycleMs = cycleMs;
      next_txValid = 1'b0;
      next_txKind = txKind;
      next_txDest = txDest;
      next_txPayload = txPayload;
      next_regRdData = 32'h0000_0000;

      // Host register reads; a read of received data consumes it
      if (regRd) begin
         case (regAddr)
            REG_CTRL: next_regRdData = {30'h0, autoAlloc, linkRun};
            REG_STATUS: begin
               next_regRdData = {12'h000, unitS2, 3'h0, rxNew, txPending,
                                 (state == ST_HOLD), isPoller, !addrValid, 2'h0, ownAddr};
            end
            REG_PARAM_MEM: next_regRdData = paramMem;
            REG_PARAM_COMMON: next_regRdData = paramCommon;
            REG_PARAM_ACTIVE: next_regRdData = effParam;
            REG_TX_DATA: next_regRdData = {16'h0000, txData};
            REG_RX_DATA: begin
               next_regRdData = {10'h000, rxFrom, rxData};
               next_rxNew = 1'b0;
            end
            4'h8, 4'h9, 4'ha, 4'hb: begin
               next_regRdData = {16'h0000, memberMap[{regAddr[1:0], 4'h0} +: 16]};
            end
            default: next_regRdData = 32'h0000_0000;
         endcase
      end
      if (regWr) begin
         case (regAddr)
            REG_CTRL: begin
               next_linkRun = regWrData[CTRL_LINK_RUN];
               next_autoAlloc = regWrData[CTRL_AUTO_ALLOC];
            end
            REG_PARAM_MEM: next_paramMem = regWrData;
            REG_PARAM_COMMON: next_paramCommon = regWrData;
            REG_TX_DATA: begin
               next_txData = regWrData[15:0];
               next_txPending = 1'b1;
            end
            default: next_txPending = txPending;
         endcase
      end

      // Cycle timer runs only with the data link up
      if (linkRun) begin
         if (cyclePre >= 32'(CYCLE_UNIT_CYC - 1)) begin
            next_cyclePre = 32'h0000_0000;
            if (cycleMs != 8'hff) begin
               next_cycleMs = cycleMs + 8'h01;
            end
         end else begin
            next_cyclePre = cyclePre + 32'h0000_0001;
         end
      end

      // Frames from other nodes
      if (rxValid && addrValid) begin
         next_silenceCnt = 32'h0000_0000;
         case (rxKind)
            KIND_DATA: begin
               next_rxData = rxPayload;
               next_rxFrom = rxSrc;
               next_rxNew = 1'b1;
            end
            KIND_MEMBER: begin
               next_memberMap[{rxDest[1:0], 4'h0} +: 16] = rxPayload;
               if (rxSrc < ownAddr) begin
                  next_isPoller = 1'b0;
               end
            end
            KIND_PARAM: begin
               if (rxDest[0]) begin
                  next_rxParam[15:0] = rxPayload;
               end else begin
                  next_rxParam[31:16] = rxPayload;
               end
            end
            KIND_POLL: begin
               if (rxSrc < ownAddr) begin
                  next_isPoller = 1'b0;
               end
               if (rxDest == ownAddr && state == ST_IDLE) begin
                  next_txValid = 1'b1;
                  next_txKind = KIND_POLL_ACK;
                  next_txDest = rxSrc;
                  next_txPayload = 16'h0000;
               end
            end
            KIND_TOKEN: begin
               if (rxDest == ownAddr && state == ST_IDLE) begin
                  if (isPoller) begin
                     next_state = ST_POLL_TX;
                     next_pollLeft = effParam[PAR_POLLED +: 8];
                  end else begin
                     next_state = ST_HOLD;
                  end
               end
            end
            default: next_state = next_state;
         endcase
      end

      // Silence: lower nodes are gone; lowest survivor times out first
      if (!isPoller && state == ST_IDLE && addrValid &&
          silenceCnt >= 32'(SILENCE_CYC * int'(ownAddr))) begin
         next_isPoller = 1'b1;
         next_state = ST_POLL_TX;
         next_pollLeft = localParam[PAR_POLLED +: 8];
         for (int i = 0; i < 64; i++) begin
            if (6'(i) < ownAddr) begin
               next_memberMap[i] = 1'b0;
            end
         end
      end

      case (state)
         ST_IDLE: next_state = next_state;
         ST_HOLD: begin
            if (txPending) begin
               next_txValid = 1'b1;
               next_txKind = KIND_DATA;
               next_txDest = DEST_ALL;
               next_txPayload = txData;
               next_txPending = regWr && (regAddr == REG_TX_DATA);
            end else if (isPoller && (!nextUp[6] || maxNode <= ownAddr)) begin
               next_state = ST_POLL_TX;
               next_pollLeft = localParam[PAR_POLLED +: 8];
            end else begin
               next_txValid = 1'b1;
               next_txKind = KIND_TOKEN;
               next_txDest = nextUp[6] ? nextUp[5:0] : lowest[5:0];
               next_txPayload = 16'h0000;
               next_state = ST_IDLE;
            end
         end
         ST_POLL_TX: begin
            if (pollLeft == 8'h00 || maxNode < 6'h02) begin
               next_state = ST_BCAST;
               next_bcastIdx = 3'h0;
            end else begin
               next_pollLeft = pollLeft - 8'h01;
               next_pollAddr = (pollAddr >= maxNode) ? 6'h01 : pollAddr + 6'h01;
               if (next_pollAddr != ownAddr) begin
                  next_txValid = 1'b1;
                  next_txKind = KIND_POLL;
                  next_txDest = next_pollAddr;
                  next_txPayload = 16'h0000;
                  next_waitCnt = 16'(POLL_WAIT_CYC);
                  next_state = ST_POLL_WAIT;
               end
            end
         end
         ST_POLL_WAIT: begin
            if (rxValid && rxKind == KIND_POLL_ACK && rxSrc == pollAddr && rxDest == ownAddr) begin
               next_memberMap[pollAddr] = 1'b1;
               next_state = ST_POLL_TX;
            end else if (waitCnt == 16'h0000) begin
               next_memberMap[pollAddr] = 1'b0;
               next_state = ST_POLL_TX;
            end else begin
               next_waitCnt = waitCnt - 16'h0001;
            end
         end
         ST_BCAST: begin
            next_txValid = 1'b1;
            next_bcastIdx = bcastIdx + 3'h1;
            if (bcastIdx < 3'h4) begin
               next_txKind = KIND_MEMBER;
               next_txDest = {4'h0, bcastIdx[1:0]};
               next_txPayload = memberMap[{bcastIdx[1:0], 4'h0} +: 16];
            end else begin
               next_txKind = KIND_PARAM;
               next_txDest = {5'h00, bcastIdx[0]};
               next_txPayload = bcastIdx[0] ? localParam[15:0] : localParam[31:16];
            end
            if (bcastIdx == 3'h5) begin
               next_state = ST_CYCLE_WAIT;
            end
         end
         ST_CYCLE_WAIT: begin
            if (!(linkRun && cycleMs < localParam[PAR_CYCLE +: 8])) begin
               next_state = ST_HOLD;
               next_cyclePre = 32'h0000_0000;
               next_cycleMs = 8'h00;
            end
         end
         default: next_state = ST_IDLE;
      endcase

      if (addrValid) begin
         next_memberMap[ownAddr] = 1'b1;
      end else begin
         next_state = ST_IDLE;
         next_isPoller = 1'b0;
         next_txValid = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         isPoller <= 1'b0;
         memberMap <= 64'h0;
         rxParam <= PARAM_RESET;
         linkRun <= 1'b0;
         autoAlloc <= 1'b0;
         paramMem <= PARAM_RESET;
         paramCommon <= PARAM_RESET;
         txData <= 16'h0000;
         txPending <= 1'b0;
         rxData <= 16'h0000;
         rxFrom <= 6'h00;
         rxNew <= 1'b0;
         pollAddr <= 6'h00;
         pollLeft <= 8'h00;
         waitCnt <= 16'h0000;
         bcastIdx <= 3'h0;
         silenceCnt <= 32'h0000_0000;
         cyclePre <= 32'h0000_0000;
         cycleMs <= 8'h00;
         txValid <= 1'b0;
         txKind <= 3'h0;
         txDest <= 6'h00;
         txPayload <= 16'h0000;
         regRdData <= 32'h0000_0000;
      end else begin
         state <= next_state;
         isPoller <= next_isPoller;
         memberMap <= next_memberMap;
         rxParam <= next_rxParam;
         linkRun <= next_linkRun;
         autoAlloc <= next_autoAlloc;
         paramMem <= next_paramMem;
         paramCommon <= next_paramCommon;
         txData <= next_txData;
         txPending <= next_txPending;
         rxData <= next_rxData;
         rxFrom <= next_rxFrom;
         rxNew <= next_rxNew;
         pollAddr <= next_pollAddr;
         pollLeft <= next_pollLeft;
         waitCnt <= next_waitCnt;
         bcastIdx <= next_bcastIdx;
         silenceCnt <= next_silenceCnt;
         cyclePre <= next_cyclePre;
         cycleMs <= next_cycleMs;
         txValid <= next_txValid;
         txKind <= next_txKind;
         txDest <= next_txDest;
         txPayload <= next_txPayload;
         regRdData <= next_regRdData;
      end
   end

   assign txSrc = ownAddr;
   assign addrErr = !addrValid;
   assign pollerActive = isPoller;
   assign tokenHeld = (state == ST_HOLD);

endmodule

// [verilog/tbac_pkg.sv]
// Constants, register map and types for the token bus access controller
// Operation
// - Transmit on the shared bus only while holding the circulating token; poll acks go out from idle without it.
// - Token cycle starts at lowest address and advances in ascending order.
// - Token received with nothing queued is forwarded at once, no data sent.
// - Highest active node hands the token back to the lowest node.
// - Lowest-addressed node normally takes the polling-node role.
// - On polling node failure the next higher node takes over automatically.
// - After each token cycle the polling node polls for joined or left nodes.
// - After polling, membership is broadcast to every node.
// - After polling and update, polling node releases the token again.
// - Polling node sends cycle time, polled count, frames, max address; others use them.
// - Link runs on startup node's parameters: memory area or common set.
// - Host hands local data in and collects remote data each refresh.
// - Node address outside 01 to 62 is a communications error, raise error.
// - Nodes above the configured maximum node address are never polled.
// - Each polling cycle polls only the configured number of nodes.
// - Cycle timer holds cycle length only while the data link operates.
package tbac_pkg;

   // ---------------------------------------------------------------
   // Register word offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_PARAM_MEM = 4'h2;
   localparam logic [3:0] REG_PARAM_COMMON = 4'h3;
   localparam logic [3:0] REG_PARAM_ACTIVE = 4'h4;
   localparam logic [3:0] REG_TX_DATA = 4'h5;
   localparam logic [3:0] REG_RX_DATA = 4'h6;
   localparam logic [3:0] REG_MEMBER0 = 4'h8;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_LINK_RUN = 0;
   localparam int CTRL_AUTO_ALLOC = 1;
   localparam int STAT_ADDR_ERR = 8;
   localparam int STAT_POLLER = 9;
   localparam int STAT_TOKEN = 10;
   localparam int STAT_TX_PEND = 11;
   localparam int STAT_RX_NEW = 12;
   localparam int STAT_UNIT = 16;
   // Parameter word: cycle time, max address, polled units, max frames
   localparam int PAR_CYCLE = 24;
   localparam int PAR_MAXNODE = 16;
   localparam int PAR_POLLED = 8;

   // ---------------------------------------------------------------
   // Reset values and limits
   // ---------------------------------------------------------------
   localparam logic [31:0] PARAM_RESET = 32'h003e_040a;
   localparam logic [7:0] ADDR_LOWEST = 8'h01;
   localparam logic [7:0] ADDR_HIGHEST = 8'h3e;
   localparam logic [5:0] DEST_ALL = 6'h3f;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int POLL_WAIT_NS = 2000;
   localparam int POLL_WAIT_CYC = (POLL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      KIND_TOKEN = 3'b000,
      KIND_DATA = 3'b001,
      KIND_POLL = 3'b010,
      KIND_POLL_ACK = 3'b011,
      KIND_MEMBER = 3'b100,
      KIND_PARAM = 3'b101
   } tbac_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HOLD = 3'b001,
      ST_POLL_TX = 3'b010,
      ST_POLL_WAIT = 3'b011,
      ST_BCAST = 3'b100,
      ST_CYCLE_WAIT = 3'b101
   } tbac_state_t;

endpackage

// [tb/tbac_mac_asserts.sv]
// Port-level checks for the token bus access controller
`timescale 1ns/10ps
module tbac_mac_asserts
   import tbac_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic rxValid,
   input wire logic [2:0] rxKind,
   input wire logic [5:0] rxDest,
   input wire logic txValid,
   input wire logic [2:0] txKind,
   input wire logic [5:0] txDest,
   input wire logic [5:0] txSrc,
   input wire logic addrErr,
   input wire logic pollerActive,
   input wire logic tokenHeld
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   logic idle;
   assign idle = !tokenHeld && !pollerActive && !addrErr;

   property p_data_in_turn;
      txValid && txKind == KIND_DATA |-> $past(tokenHeld);
   endproperty
   a_data_in_turn: assert property (p_data_in_turn) else $error("data without token");

   property p_token_taken;
      idle && rxValid && rxKind == KIND_TOKEN && rxDest == txSrc |=> tokenHeld;
   endproperty
   a_token_taken: assert property (p_token_taken) else $error("token not taken");

   property p_token_leaves;
      txValid && txKind == KIND_TOKEN && !pollerActive |-> $past(tokenHeld) && !tokenHeld;
   endproperty
   a_token_leaves: assert property (p_token_leaves) else $error("token pass state");

   property p_token_elsewhere;
      txValid && txKind == KIND_TOKEN |-> txDest != txSrc && txDest != 6'h00;
   endproperty
   a_token_elsewhere: assert property (p_token_elsewhere) else $error("token to self");

   property p_poll_answer;
      idle && rxValid && rxKind == KIND_POLL && rxDest == txSrc
         |=> txValid && txKind == KIND_POLL_ACK;
   endproperty
   a_poll_answer: assert property (p_poll_answer) else $error("poll not answered");

   property p_control_by_poller;
      txValid && (txKind == KIND_POLL || txKind == KIND_MEMBER || txKind == KIND_PARAM)
         |-> pollerActive;
   endproperty
   a_control_by_poller: assert property (p_control_by_poller) else $error("not poller");

   property p_param_pair;
      txValid && txKind == KIND_PARAM && txDest == 6'h00
         |=> txValid && txKind == KIND_PARAM && txDest == 6'h01;
   endproperty
   a_param_pair: assert property (p_param_pair) else $error("param half missing");

   property p_member_run;
      txValid && txKind == KIND_MEMBER && txDest == 6'h00
         |=> (txValid && txKind == KIND_MEMBER)[*3] ##1 (txValid && txKind == KIND_PARAM);
   endproperty
   a_member_run: assert property (p_member_run) else $error("broadcast broken");

   property p_addr_err_deaf;
      addrErr && !tokenHeld && !pollerActive && rxValid |=> !tokenHeld && !txValid;
   endproperty
   a_addr_err_deaf: assert property (p_addr_err_deaf) else $error("bad address acted");

   property p_poll_range;
      txValid && txKind == KIND_POLL |-> txDest != txSrc && txDest >= 6'h01 && txDest <= 6'h3e;
   endproperty
   a_poll_range: assert property (p_poll_range) else $error("poll out of range");

   c_forward: cover property (txValid && txKind == KIND_TOKEN && !pollerActive);
   c_poll: cover property (txValid && txKind == KIND_POLL);
   c_param: cover property (txValid && txKind == KIND_PARAM);
endmodule

bind tbac_mac tbac_mac_asserts i_tbac_mac_asserts (.clock(clock), .sys_rst(sys_rst),
   .rxValid(rxValid), .rxKind(rxKind), .rxDest(rxDest), .txValid(txValid), .txKind(txKind),
   .txDest(txDest), .txSrc(txSrc), .addrErr(addrErr), .pollerActive(pollerActive),
   .tokenHeld(tokenHeld));

// [tb/tbac_node_model.sv]
// Behavioural model of the other nodes sharing the bus
`timescale 1ns/10ps
module tbac_node_model
   import tbac_pkg::*;
#(
   parameter logic [5:0] PEER = 6'h29
) (
   input wire logic clock,
   input wire logic txValid,
   input wire logic [2:0] txKind,
   input wire logic [5:0] txDest,
   input wire logic [5:0] txSrc,
   output logic rxValid,
   output logic [2:0] rxKind,
   output logic [5:0] rxDest,
   output logic [5:0] rxSrc,
   output logic [15:0] rxPayload
);
   logic [2:0] k;
   logic [5:0] d;

   initial begin
      rxValid = 1'b0;
      rxKind = 3'h7;
      rxDest = 6'h00;
      rxSrc = 6'h00;
      rxPayload = 16'h0000;
   end

   // ---------------------------------------------------------------
   // Frame sender, called at a rising edge
   // ---------------------------------------------------------------
   task automatic send(input logic [2:0] kk, input logic [5:0] dd, input logic [5:0] ss,
                       input logic [15:0] pp);
      rxValid <= 1'b1;
      rxKind <= kk;
      rxDest <= dd;
      rxSrc <= ss;
      rxPayload <= pp;
      @(posedge clock);
      // Released lines show junk, not a stale frame
      rxValid <= 1'b0;
      rxKind <= ~kk;
      rxDest <= ~dd;
      rxSrc <= ~ss;
      rxPayload <= ~pp;
      @(posedge clock);
   endtask

   // Peer is the highest member: acks polls and closes the ring
   always @(posedge clock) begin
      if (txValid && txDest == PEER && (txKind == KIND_POLL || txKind == KIND_TOKEN)) begin
         k = (txKind == KIND_POLL) ? KIND_POLL_ACK : KIND_TOKEN;
         d = txSrc;
         repeat (2) @(posedge clock);
         send(k, d, PEER, 16'h0000);
      end
   end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the token bus access controller
`timescale 1ns/10ps
module testbench
   import tbac_pkg::*;
();
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] tensSw = 4'h4;
   logic [3:0] onesSw = 4'h0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdData, rdv;
   logic rxValid, txValid, addrErr, pollerActive, tokenHeld;
   logic [2:0] rxKind, txKind;
   logic [5:0] rxDest, rxSrc, txDest, txSrc;
   logic [15:0] rxPayload, txPayload;
   logic [24:0] log[$];
   int n_fail = 0;
   int n_checks = 0;
   always #4 clock = ~clock;
   tbac_mac #(.SILENCE_CYC(20), .CYCLE_UNIT_CYC(10)) i_tbac_mac (.clock(clock),
      .sys_rst(sys_rst), .addrTensSw(tensSw), .addrOnesSw(onesSw), .unitSw(4'h9),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .rxValid(rxValid), .rxKind(rxKind), .rxDest(rxDest),
      .rxSrc(rxSrc), .rxPayload(rxPayload), .txValid(txValid), .txKind(txKind),
      .txDest(txDest), .txSrc(txSrc), .txPayload(txPayload), .addrErr(addrErr),
      .pollerActive(pollerActive), .tokenHeld(tokenHeld));

   tbac_node_model i_tbac_node_model (.clock(clock), .txValid(txValid), .txKind(txKind),
      .txDest(txDest), .txSrc(txSrc), .rxValid(rxValid), .rxKind(rxKind), .rxDest(rxDest),
      .rxSrc(rxSrc), .rxPayload(rxPayload));

   always @(posedge clock) begin
      if (txValid === 1'b1)
         log.push_back({txKind, txDest, txPayload});
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      if (n_fail == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic tmo(input logic ok);
      chk(ok, 1'b1);
      if (ok !== 1'b1)
         stop_test();
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWr <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [3:0] a);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      @(negedge clock);
      rdv = regRdData;
      @(posedge clock);
   endtask

   task automatic tx(input logic [2:0] k, input logic [5:0] d, input logic [15:0] p);
      i_tbac_node_model.send(k, d, 6'h02, p);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd(REG_STATUS);
      chk(rdv, 32'h0009_0028);
      rd(REG_PARAM_ACTIVE);
      chk(rdv, PARAM_RESET);
      wr(REG_STATUS, 32'hffff_ffff);
      wr(4'h7, 32'hffff_ffff);
      rd(4'h7);
      chk(rdv, 32'h0);
      rd(REG_STATUS);
      chk(rdv, 32'h0009_0028);
   endtask

   task automatic t_addr();
      logic [7:0] bad[4] = '{8'h63, 8'h00, 8'h0a, 8'h70};
      for (int i = 0; i < 4; i++) begin
         tensSw <= bad[i][7:4];
         onesSw <= bad[i][3:0];
         repeat (4) @(posedge clock);
         chk(addrErr, 1'b1);
         tx(KIND_TOKEN, txSrc, 16'h0000);
         chk(tokenHeld, 1'b0);
      end
      tensSw <= 4'h4;
      onesSw <= 4'h0;
      repeat (4) @(posedge clock);
      chk(addrErr, 1'b0);
   endtask

   task automatic t_ring();
      tx(KIND_MEMBER, 6'h00, 16'h0004);
      tx(KIND_MEMBER, 6'h01, 16'h0000);
      tx(KIND_MEMBER, 6'h02, 16'h1100);
      tx(KIND_MEMBER, 6'h03, 16'h0000);
      tx(KIND_PARAM, 6'h00, 16'h003e);
      tx(KIND_PARAM, 6'h01, 16'h0308);
      rd(REG_PARAM_ACTIVE);
      chk(rdv, 32'h003e_0308);
      rd(REG_MEMBER0 + 4'h2);
      chk(rdv, 32'h0000_1100);
      log.delete();
      tx(KIND_POLL, 6'h28, 16'h0000);
      tx(KIND_TOKEN, 6'h28, 16'h0000);
      repeat (4) @(posedge clock);
      chk(log.size(), 2);
      chk(log[0][24:22], KIND_POLL_ACK);
      chk(log[1][24:16], {KIND_TOKEN, 6'h2c});
      wr(REG_TX_DATA, 32'h0000_beef);
      rd(REG_STATUS);
      chk(rdv[STAT_TX_PEND], 1'b1);
      log.delete();
      tx(KIND_TOKEN, 6'h28, 16'h0000);
      repeat (4) @(posedge clock);
      chk(log[0], {KIND_DATA, DEST_ALL, 16'hbeef});
      chk(log[1][24:16], {KIND_TOKEN, 6'h2c});
      tx(KIND_DATA, DEST_ALL, 16'h1234);
      rd(REG_RX_DATA);
      chk(rdv, 32'h0002_1234);
      tx(KIND_MEMBER, 6'h02, 16'h0100);
      log.delete();
      tx(KIND_TOKEN, 6'h28, 16'h0000);
      repeat (4) @(posedge clock);
      chk(log[0][24:16], {KIND_TOKEN, 6'h02});
   endtask

   task automatic t_poller();
      int n;
      log.delete();
      wr(REG_PARAM_MEM, 32'h012a_0205);
      wr(REG_CTRL, 32'h0000_0003);
      for (int i = 0; i < 1200 && pollerActive !== 1'b1; i++)
         @(posedge clock);
      tmo(pollerActive);
      // Peer is reached late in the round robin
      for (int i = 0; i < 30000 && !(log.size() > 0 && log[$][24:22] == KIND_TOKEN); i++)
         @(posedge clock);
      n = log.size();
      tmo(n >= 9 && log[n-1][24:22] == KIND_TOKEN);
      chk(log[n-1][24:16], {KIND_TOKEN, 6'h29});
      chk(log[n-2], {KIND_PARAM, 6'h01, 16'h0205});
      chk(log[n-3], {KIND_PARAM, 6'h00, 16'h012a});
      for (int i = 0; i < 4; i++)
         chk(log[n-7+i][24:16], {KIND_MEMBER, 6'(i)});
      chk(log[n-5][9], 1'b1);
      chk({log[n-9][24:22], log[n-8][24:22]}, {KIND_POLL, KIND_POLL});
      if (n > 9)
         chk(log[n-10][24:22], KIND_PARAM);
      foreach (log[i])
         if (log[i][24:22] == KIND_POLL)
            chk(log[i][21:16] <= 6'h2a && log[i][21:16] != 6'h28, 1'b1);
      rd(REG_PARAM_ACTIVE);
      chk(rdv, 32'h012a_0205);
      wr(REG_CTRL, 32'h0000_0001);
      rd(REG_PARAM_ACTIVE);
      chk(rdv, PARAM_RESET);
   endtask

   initial begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_addr();
      t_ring();
      t_poller();
      stop_test();
   end
endmodule
